// [rtl/pfb_pkg.sv]
// Purpose: Constants for the power-fail and backup-supply control block
// Assumes: 10 MHz clock, synchronous active-low reset
// Notes:   Long counts are top-level parameters derived from these times
//
// Notes on behaviour
// RQ1 - Flag low when monitored level below trip
// RQ2 - Main below backup: comparator off, flag low
// RQ3 - Flag forced high during reset timeout
// RQ4 - Reset held while manual low, plus 200ms
// RQ5 - Seal arms only with manual input high
// RQ6 - Armed seal ignores manual reset input
// RQ7 - Backup mode needs below-reset and below-backup
// RQ8 - Output supply: main above reset, else higher
// RQ9 - Backup mode: reset low, watchdog disabled
// RQ10 - Backup mode: chip-select out high, input hi-Z
// RQ11 - Undriven kick input serviced internally
// RQ12 - Processor pulses kick within seven-eighths timeout
// RQ13 - No backup mode while main above reset
// RQ14 - Reset held full timeout after main recovers
// RQ15 - Missing kick within 1.6s asserts reset
// RQ16 - Chip-select pass disabled during reset
// RQ17 - Comparator inputs pass two-stage synchroniser
package pfb_pkg;

  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned RESET_TIME_MS  = 200;
  localparam int unsigned WDOG_TIME_MS   = 1600;
  localparam int unsigned RESET_CYCLES   = (CLK_HZ / 1000) * RESET_TIME_MS;
  localparam int unsigned WDOG_CYCLES    = (CLK_HZ / 1000) * WDOG_TIME_MS;
  localparam int unsigned SYNC_STAGES    = 2;
  localparam int unsigned CNT_W          = 25;
  localparam logic        SUPPLY_MAIN    = 1'b0;
  localparam logic        SUPPLY_BACKUP  = 1'b1;

  typedef enum logic [1:0] {
    PFB_ST_HOLD   = 2'b00,
    PFB_ST_RUN    = 2'b01,
    PFB_ST_BACKUP = 2'b11
  } pfb_state_e;

endpackage : pfb_pkg

// [rtl/pfb_sync.sv]
// Purpose: Two-flop synchroniser for a bus of asynchronous levels
// Assumes: Inputs come from outside the clock domain
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module pfb_sync
  import pfb_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : pfb_sync

// [rtl/pfb_ctrl.sv]
// Purpose: Power-fail flag, backup switchover, reset and watchdog control
// Assumes: Comparator decisions arrive as asynchronous levels
// Notes:   Seal arming is sampled when reset timeout ends with manual input high
`timescale 1ns/100ps
module pfb_ctrl
  import pfb_pkg::*;
#(
  parameter int unsigned RESET_CNT = RESET_CYCLES,
  parameter int unsigned WDOG_CNT  = WDOG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic level_below_trip,
  input  wire logic main_below_reset,
  input  wire logic main_below_backup,
  input  wire logic manual_reset_n,
  input  wire logic watchdog_kick,
  input  wire logic watchdog_kick_driven,
  input  wire logic chip_select_in_n,
  output logic      powerfail_flag_n,
  output logic      reset_out_n,
  output logic      supply_select,
  output logic      backup_mode,
  output logic      watchdog_enable,
  output logic      chip_select_out_n,
  output logic      chip_select_in_hiz,
  output logic      seal_armed,
  output logic      internal_kick
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronised inputs
  // Chip-select input is a pin too, so it takes the same two flops
  logic [6:0] sync_v;

  pfb_sync #(.WIDTH(7)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in ({level_below_trip, main_below_reset, main_below_backup,
                manual_reset_n, watchdog_kick, watchdog_kick_driven,
                chip_select_in_n}),
    .sync_out (sync_v)
  ); // [RQ17]

  wire s_lvl_low  = sync_v[6];
  wire s_main_low = sync_v[5];
  wire s_main_bk  = sync_v[4];
  wire s_mr_n     = sync_v[3];
  wire s_kick     = sync_v[2];
  wire s_kick_drv = sync_v[1];
  wire s_cs_n     = sync_v[0];

  ////////////////////////////////////////////////////////////////////////////
  // State and counters
  pfb_state_e       state_ff, nxt_state;
  logic [CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
  logic [CNT_W-1:0] wd_cnt_ff, nxt_wd_cnt;
  logic             kick_ff;
  logic             seal_ff, nxt_seal;
  logic             pf_n_ff, rst_n_ff, bk_ff, sel_ff, cs_n_ff, hiz_ff, ikick_ff;

  wire in_backup  = s_main_low && s_main_bk;                      // [RQ7] [RQ13]
  // Manual input is disregarded once the seal is armed
  wire mr_active  = !s_mr_n && !seal_ff;                          // [RQ6]
  wire kick_eff   = s_kick_drv ? s_kick : ikick_ff;               // [RQ11]
  wire kick_edge  = kick_eff && !kick_ff;
  wire wd_expire  = (state_ff == PFB_ST_RUN) &&
                    (wd_cnt_ff == CNT_W'(WDOG_CNT - 1));          // [RQ15]
  wire rst_done   = (rst_cnt_ff == CNT_W'(RESET_CNT - 1));
  wire seven_8th  = (wd_cnt_ff == CNT_W'((WDOG_CNT / 8) * 7));

  always_comb begin
    nxt_state   = state_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_wd_cnt  = wd_cnt_ff;
    nxt_seal    = seal_ff;
    case (state_ff)
      PFB_ST_HOLD: begin
        nxt_wd_cnt = '0;
        if (in_backup) begin
          nxt_state   = PFB_ST_BACKUP;
          nxt_rst_cnt = '0;
        end else if (s_main_low || mr_active) begin
          nxt_rst_cnt = '0;                                       // [RQ4] [RQ14]
        end else if (rst_done) begin
          nxt_state = PFB_ST_RUN;
          // Seal arms only if manual input high at end of timeout
          if (s_mr_n) begin
            nxt_seal = 1'b1;                                      // [RQ5]
          end
        end else begin
          nxt_rst_cnt = rst_cnt_ff + 1'b1;
        end
      end
      PFB_ST_RUN: begin
        nxt_rst_cnt = '0;
        if (in_backup) begin
          nxt_state = PFB_ST_BACKUP;
        end else if (s_main_low || mr_active || wd_expire) begin
          nxt_state = PFB_ST_HOLD;                                // [RQ15]
        end else if (kick_edge) begin
          nxt_wd_cnt = '0;
        end else begin
          nxt_wd_cnt = wd_cnt_ff + 1'b1;
        end
      end
      PFB_ST_BACKUP: begin
        nxt_rst_cnt = '0;
        nxt_wd_cnt  = '0;                                         // [RQ9]
        if (!in_backup) begin
          nxt_state = PFB_ST_HOLD;
        end
      end
      default: nxt_state = PFB_ST_HOLD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output decode
  wire in_timeout = (state_ff == PFB_ST_HOLD) && !s_main_low && !mr_active;
  wire nxt_pf_n   = s_main_bk  ? 1'b0 :                           // [RQ2]
                    in_timeout ? 1'b1 :                           // [RQ3]
                    !s_lvl_low;                                   // [RQ1]
  wire nxt_rst_n  = (nxt_state == PFB_ST_RUN);                    // [RQ9] [RQ14]
  wire nxt_bk     = (nxt_state == PFB_ST_BACKUP);
  wire nxt_sel    = (s_main_low && s_main_bk) ? SUPPLY_BACKUP : SUPPLY_MAIN; // [RQ8]
  wire nxt_hiz    = !nxt_rst_n;                                   // [RQ10] [RQ16]
  wire nxt_cs_n   = nxt_rst_n ? s_cs_n : 1'b1;                    // [RQ10] [RQ16]
  // Internal pulse high one cycle at seven-eighths of the timeout
  wire nxt_ikick  = (state_ff == PFB_ST_RUN) && seven_8th;        // [RQ11]

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff   <= PFB_ST_HOLD;
      rst_cnt_ff <= '0;
      wd_cnt_ff  <= '0;
      kick_ff    <= 1'b0;
      seal_ff    <= 1'b0;
      pf_n_ff    <= 1'b1;
      rst_n_ff   <= 1'b0;
      bk_ff      <= 1'b0;
      sel_ff     <= SUPPLY_MAIN;
      cs_n_ff    <= 1'b1;
      hiz_ff     <= 1'b1;
      ikick_ff   <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      rst_cnt_ff <= nxt_rst_cnt;
      wd_cnt_ff  <= nxt_wd_cnt;
      kick_ff    <= kick_eff;
      seal_ff    <= nxt_seal;
      pf_n_ff    <= nxt_pf_n;
      rst_n_ff   <= nxt_rst_n;
      bk_ff      <= nxt_bk;
      sel_ff     <= nxt_sel;
      cs_n_ff    <= nxt_cs_n;
      hiz_ff     <= nxt_hiz;
      ikick_ff   <= nxt_ikick;
    end
  end

  assign powerfail_flag_n   = pf_n_ff;
  assign reset_out_n        = rst_n_ff;
  assign backup_mode        = bk_ff;
  assign supply_select      = sel_ff;
  assign chip_select_out_n  = cs_n_ff;
  assign chip_select_in_hiz = hiz_ff;
  assign watchdog_enable    = (state_ff == PFB_ST_RUN);           // [RQ9]
  assign seal_armed         = seal_ff;
  assign internal_kick      = ikick_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_flag_trip;
    @(posedge clk) disable iff (!rst_b)
      (s_lvl_low && !s_main_bk && !in_timeout) |=> !powerfail_flag_n;
  endproperty
  a_flag_trip: assert property (p_flag_trip) else $error("flag not low on trip"); // [RQ1]

  property p_flag_bk;
    @(posedge clk) disable iff (!rst_b) s_main_bk |=> !powerfail_flag_n;
  endproperty
  a_flag_bk: assert property (p_flag_bk) else $error("flag not low below backup"); // [RQ2]

  property p_flag_tmo;
    @(posedge clk) disable iff (!rst_b) (in_timeout && !s_main_bk) |=> powerfail_flag_n;
  endproperty
  a_flag_tmo: assert property (p_flag_tmo) else $error("flag not high in timeout"); // [RQ3]

  property p_mr_hold;
    @(posedge clk) disable iff (!rst_b) mr_active |=> !reset_out_n;
  endproperty
  a_mr_hold: assert property (p_mr_hold) else $error("reset released with manual low"); // [RQ4]

  property p_seal;
    @(posedge clk) disable iff (!rst_b) $rose(seal_ff) |-> $past(s_mr_n);
  endproperty
  a_seal: assert property (p_seal) else $error("seal armed with manual low"); // [RQ5]

  property p_bk_cond;
    @(posedge clk) disable iff (!rst_b) backup_mode |-> $past(in_backup);
  endproperty
  a_bk_cond: assert property (p_bk_cond) else $error("backup without both conditions"); // [RQ7]

  property p_bk_out;
    @(posedge clk) disable iff (!rst_b)
      backup_mode |-> (!reset_out_n && chip_select_out_n && chip_select_in_hiz);
  endproperty
  a_bk_out: assert property (p_bk_out) else $error("backup outputs wrong"); // [RQ10]

  property p_wd_off;
    @(posedge clk) disable iff (!rst_b) backup_mode |-> !watchdog_enable;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog on in backup"); // [RQ9]

  property p_rel;
    @(posedge clk) disable iff (!rst_b) $rose(reset_out_n) |-> $past(rst_done);
  endproperty
  a_rel: assert property (p_rel) else $error("reset released early"); // [RQ14]

  property p_cs_rst;
    @(posedge clk) disable iff (!rst_b) !reset_out_n |-> chip_select_out_n;
  endproperty
  a_cs_rst: assert property (p_cs_rst) else $error("chip select passed in reset"); // [RQ16]

  c_backup:  cover property (@(posedge clk) $rose(backup_mode));
  c_release: cover property (@(posedge clk) $rose(reset_out_n));
  c_wdog:    cover property (@(posedge clk) wd_expire);
  c_seal:    cover property (@(posedge clk) $rose(seal_ff));

endmodule : pfb_ctrl

// [verif/pfb_cpu_model.sv]
// Purpose: Processor-side model that services the watchdog and drives chip select
// Assumes: Kicks are sent only while reset is released and kicking is enabled
// Notes:   Pulse period sits well inside seven-eighths of the shortened timeout
`timescale 1ns/100ps
module pfb_cpu_model #(
  parameter int unsigned KICK_GAP = 20
) (
  input  wire logic clk,
  input  wire logic reset_out_n,
  input  wire logic kick_on,
  output logic      watchdog_kick,
  output logic      chip_select_in_n
);
  int unsigned gap_cnt;
  int unsigned cs_cnt;

  initial begin
    watchdog_kick = 1'b0;
    chip_select_in_n = 1'b1;
    gap_cnt = 0;
    cs_cnt = 0;
  end

  // Kick rests low and rises for two cycles, so the synchroniser cannot miss it
  always @(posedge clk) begin
    #10;
    cs_cnt++;
    chip_select_in_n = cs_cnt[3];
    if (reset_out_n !== 1'b1 || !kick_on) begin
      gap_cnt = 0;
    end else begin
      gap_cnt++;
    end
    watchdog_kick = (gap_cnt >= KICK_GAP - 1);
    if (gap_cnt >= KICK_GAP) begin
      gap_cnt = 0;
    end
  end
endmodule : pfb_cpu_model

// [verif/test_powerfail_backup_control.sv]
// Purpose: Self-checking bench for the power-fail and backup control block
// Assumes: Shortened reset and watchdog counts via parameters
// Notes:   Seal arms early, so manual reset is exercised before it
`timescale 1ns/100ps
module test_powerfail_backup_control;
  import pfb_pkg::*;
  localparam int unsigned RST_N = 20;
  localparam int unsigned WDG_N = 64;
  logic clk, rst_b, level_below_trip, main_below_reset, main_below_backup;
  logic manual_reset_n, watchdog_kick, watchdog_kick_driven, chip_select_in_n;
  logic kick_on, powerfail_flag_n, reset_out_n, supply_select, backup_mode;
  logic watchdog_enable, chip_select_out_n, chip_select_in_hiz, seal_armed;
  logic internal_kick;
  logic [2:0] hist;
  int   errors, n_checks, seed, n, c, kicks;

  pfb_ctrl #(.RESET_CNT(RST_N), .WDOG_CNT(WDG_N)) dut (
    .clk(clk), .rst_b(rst_b), .level_below_trip(level_below_trip),
    .main_below_reset(main_below_reset), .main_below_backup(main_below_backup),
    .manual_reset_n(manual_reset_n), .watchdog_kick(watchdog_kick),
    .watchdog_kick_driven(watchdog_kick_driven), .chip_select_in_n(chip_select_in_n),
    .powerfail_flag_n(powerfail_flag_n), .reset_out_n(reset_out_n),
    .supply_select(supply_select), .backup_mode(backup_mode),
    .watchdog_enable(watchdog_enable), .chip_select_out_n(chip_select_out_n),
    .chip_select_in_hiz(chip_select_in_hiz), .seal_armed(seal_armed),
    .internal_kick(internal_kick));

  pfb_cpu_model #(.KICK_GAP(20)) cpu (
    .clk(clk), .reset_out_n(reset_out_n), .kick_on(kick_on),
    .watchdog_kick(watchdog_kick), .chip_select_in_n(chip_select_in_n));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic exp_flag(input logic below_trip, input logic below_backup);
    return !(below_trip | below_backup);
  endfunction : exp_flag

  function automatic logic exp_supply(input logic below_rst, input logic below_backup);
    return (below_rst & below_backup) ? SUPPLY_BACKUP : SUPPLY_MAIN;
  endfunction : exp_supply

  task automatic chk(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask : step

  // Counts cycles until reset output reaches the wanted level, bounded
  task automatic wait_rst(input logic lvl, output int cyc);
    cyc = 0;
    while (reset_out_n !== lvl && cyc < 1000) begin
      step(1);
      cyc++;
    end
  endtask : wait_rst

  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    #500000;
    errors++;
    results();
  end

  initial begin
    errors = 0; n_checks = 0; seed = 32'h9bb3;
    rst_b = 1'b0; level_below_trip = 1'b0; main_below_reset = 1'b1;
    main_below_backup = 1'b0; manual_reset_n = 1'b0; watchdog_kick_driven = 1'b1;
    kick_on = 1'b1;
    step(20);
    rst_b = 1'b1;
    main_below_reset = 1'b0;
    step(RST_N + 10);
    chk(reset_out_n, 1'b0);
    chk(seal_armed, 1'b0);
    chk(chip_select_out_n, 1'b1);
    chk(chip_select_in_hiz, 1'b1);
    manual_reset_n = 1'b1;
    level_below_trip = 1'b1;
    step(8);
    chk(powerfail_flag_n, 1'b1);
    wait_rst(1'b1, c);
    chk(logic'(c + 8 >= RST_N && c + 8 <= RST_N + 6), 1'b1);
    chk(seal_armed, 1'b1);
    step(4);
    chk(powerfail_flag_n, 1'b0);
    chk(watchdog_enable, 1'b1);
    manual_reset_n = 1'b0;
    step(10);
    chk(reset_out_n, 1'b1);
    manual_reset_n = 1'b1;
    repeat (40) begin
      level_below_trip = 1'($random(seed));
      main_below_backup = 1'($random(seed));
      step(5);
      chk(powerfail_flag_n, exp_flag(level_below_trip, main_below_backup));
      chk(backup_mode, 1'b0);
      chk(supply_select, SUPPLY_MAIN);
      chk(reset_out_n, 1'b1);
    end
    kick_on = 1'b0;
    wait_rst(1'b0, c);
    chk(logic'(c + 25 >= WDG_N && c <= WDG_N + 6), 1'b1);
    watchdog_kick_driven = 1'b0;
    wait_rst(1'b1, c);
    chk(logic'(c >= RST_N && c <= RST_N + 6), 1'b1);
    // Sampled mid-cycle; chip-select out lags its input by three edges
    kicks = 0;
    hist = 3'b111;
    for (n = 0; n < 3 * WDG_N; n++) begin
      @(negedge clk);
      kicks += internal_kick;
      if (n >= 3) begin
        chk(chip_select_out_n, hist[2]);
      end
      hist = {hist[1:0], chip_select_in_n};
      chk(reset_out_n, 1'b1);
    end
    chk(logic'(kicks >= 3), 1'b1);
    step(1);
    for (n = 0; n < 4; n++) begin
      {main_below_reset, main_below_backup} = n[1:0];
      step(6);
      chk(backup_mode, n[1] & n[0]);
      chk(supply_select, exp_supply(n[1], n[0]));
      if (n[1]) begin
        chk(reset_out_n, 1'b0);
      end
      if (n == 3) begin
        chk(watchdog_enable, 1'b0);
        chk(chip_select_out_n, 1'b1);
        chk(chip_select_in_hiz, 1'b1);
      end
    end
    results();
  end
endmodule : test_powerfail_backup_control
